// ---- hw/socr_regs.sv ----
// Output and modulator configuration register bank behind an APB slave.
// Assumes an APB master on pclk; outputs feed output buffers and modulator.
// Reserved fields are plain storage; software loads their fixed values.
// One clock; pready always answers in the first access cycle.
`timescale 1ns/1ns

module socr_regs #(
   parameter int ADDR_W = 12                                  // APB address width
) (
   // Clock, reset and APB slave
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [ADDR_W-1:0]             paddr,
   input  wire logic [31:0]                   pwdata,
   input  wire logic [3:0]                    pstrb,
   output logic                               pready,
   output logic [31:0]                        prdata,
   output logic                               pslverr,
   // Analog output and modulator controls, each straight from a flip-flop
   output logic [socr_pkg::DRIVE_W-1:0]       first_output_drive_current,
   output logic [socr_pkg::DRIVE_W-1:0]       second_output_drive_current,
   output logic                               first_output_powerdown,
   output logic                               second_output_powerdown,
   output logic                               modulator_reset_low,
   output logic [socr_pkg::MOD_ORDER_W-1:0]   modulator_order_select,
   output logic [socr_pkg::SRC_W-1:0]         first_output_source_select,
   output logic [socr_pkg::SRC_W-1:0]         second_output_source_select
);
   import socr_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   // The last register sits at byte 0xe0, so eight address bits are needed
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
      $error("socr_regs: ADDR_W must be 8 to 32");
   end

   // The bank is addressed by slot; the map must be dense and fit five bits
   // A wider bus gains nothing, a narrower one could not reach the top word
   if (NUM_REGS != int'(IDX_LAST) - int'(IDX_FIRST) + 1 || NUM_REGS > 32) begin : g_bad_map
      $error("socr_regs: register map is not dense or too large");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // All state lives in one packed struct: the bank words and the bus answer.
   // The answer fields are loaded in setup and cleared on completion.
   typedef struct packed {
      logic [NUM_REGS-1:0][15:0] regs;                        // Register contents
      logic                      ready;                       // Access-phase answer
      logic                      err;                         // Unmapped address
      logic [31:0]               rdata;                       // Captured read data
   } socr_state_t;

   socr_state_t state;                                        // Registered state
   socr_state_t next_state;                                   // Next value of state

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Turns a byte address into a bank slot; valid low when unmapped
   // Misaligned or out-of-range addresses leave the slot meaningless, so
   // every user of the slot must qualify it with the valid flag first.
   function automatic logic [4:0] slot_of(input logic [ADDR_W-1:0] addr,
                                          output logic valid);
      logic [ADDR_W-1:0] word;
      word  = addr >> 2;
      valid = (addr[1:0] == 2'h0) &&
              (word >= ADDR_W'(IDX_FIRST)) && (word <= ADDR_W'(IDX_LAST));
      return 5'(word - ADDR_W'(IDX_FIRST));
   endfunction : slot_of

   // Merges write data into a 16-bit word through the two low byte lanes
   // Lanes 2 and 3 have no storage behind them and are ignored.
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction : merge

   // ----------------------------------------------------------------
   // Decode of the current request
   // ----------------------------------------------------------------
   // Address map, byte address = index * 4:
   //   0xb0  output A level, power-downs, modulator reset and order
   //   0xb4  output B level, output A source, fixed reserved fields
   //   0xb8  output B source, fixed reserved field above it
   //   0xbc  fixed setting, loaded with 0x300 by software
   //   0xc0  fixed setting, loaded with 0x300 by software
   //   0xc4  fixed setting, loaded with 0x4180 by software
   //   0xc8  fixed setting, loaded with zero by software
   //   0xcc  fixed setting, loaded with 0x80 by software
   //   0xd0  fixed setting, loaded with 0x420 by software
   //   0xd4 to 0xe0  fixed settings, loaded with zero by software
   // Any other address, or one not word aligned, is refused with pslverr.
   // The bank never enforces the software values: every bit is storage.

   logic       hit;                                           // Address is mapped
   logic [4:0] slot;                                          // Bank slot of address
   logic       setup;                                         // Setup cycle
   logic       fire;                                          // Completing access

   always_comb begin
      // Setup: select without enable; fire: access with the answer standing
      slot  = slot_of(paddr, hit);
      setup = psel && !penable;
      fire  = psel && penable && state.ready;
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // The answer is prepared in the setup cycle, so pready rises in the
   // first access cycle and every transfer has no wait state.
   // Cycle by cycle:
   //   setup edge     : read word, error flag and pready are loaded
   //   access cycle   : pready, prdata and pslverr stand for this cycle
   //   completing edge: the write lands and the answer is cleared
   // Read data are taken in setup; no write can slip in before the access.
   always_comb begin
      next_state       = state;
      next_state.ready = setup;
      if (setup) begin
         next_state.err   = !hit;                             // Unmapped answers with error
         next_state.rdata = hit ? {16'h0000, state.regs[slot]} : 32'h0000_0000;
      end else if (fire) begin
         next_state.err   = 1'b0;
         next_state.rdata = 32'h0000_0000;
      end
      // Writes land only at the completing edge, never on unmapped slots
      // Byte lanes left low keep the stored byte
      if (fire && pwrite && hit) begin
         next_state.regs[slot] = merge(state.regs[slot], pwdata, pstrb);
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Asynchronous clear to the reset words; the bus answer starts idle
   // so no stale pready can follow a reset in mid-transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.regs  <= REG_RESET;
         state.ready <= 1'b0;
         state.err   <= 1'b0;
         state.rdata <= 32'h0000_0000;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all taken from the state flip-flops
   // ----------------------------------------------------------------
   // Slots count from the first register of the bank
   localparam int S44 = 0;                                    // Slot of 0x2c
   localparam int S45 = 1;                                    // Slot of 0x2d
   localparam int S46 = 2;                                    // Slot of 0x2e

   // Bus answer
   assign pready  = state.ready;
   assign pslverr = state.err;
   assign prdata  = state.rdata;

   // The controls are wired straight from the stored words, so each one
   // changes in the cycle after the write that completes on its register.
   // Unused order codes 4 to 7 and the reserved source codes are driven
   // as written; software must not hand them to the analog side.

   // Analog and modulator controls
   assign first_output_drive_current  = state.regs[S44][DRIVE_A_LSB +: DRIVE_W];
   assign second_output_drive_current = state.regs[S45][DRIVE_B_LSB +: DRIVE_W];
   assign second_output_powerdown     = state.regs[S44][PD_B_BIT];
   assign first_output_powerdown      = state.regs[S44][PD_A_BIT];
   assign modulator_reset_low         = state.regs[S44][MOD_RST_BIT];
   assign modulator_order_select      = state.regs[S44][MOD_ORDER_LSB +: MOD_ORDER_W];
   assign first_output_source_select  = state.regs[S45][SRC_A_LSB +: SRC_W];
   assign second_output_source_select = state.regs[S46][SRC_B_LSB +: SRC_W];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Each check watches design state or outputs; the bus inputs qualify
   // when a check applies and supply the expected write data.

   // Helper: a full-word write that completes this cycle
   logic wr_full;                                             // Both low lanes written
   always_comb begin
      wr_full = fire && pwrite && hit && (pstrb[1:0] == 2'h3);
   end

   // Setup is answered in the next cycle, for exactly one cycle
   a_ready_one_wait: assert property (setup |=> pready ##1 !pready)
      else $error("pready did not follow setup by one cycle");

   a_write_stores: assert property (
      wr_full |=> state.regs[$past(slot)] == $past(pwdata[15:0]))
      else $error("written word not stored");

   a_read_returns: assert property (
      setup && hit && !pwrite |=> prdata == {16'h0000, $past(state.regs[slot])} && !pslverr)
      else $error("read data does not match register");

   a_unmapped_err: assert property (
      setup && !hit |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   a_level_a: assert property (
      wr_full && slot == 5'(S44) |=> first_output_drive_current == $past(pwdata[13:8]))
      else $error("first output level not updated");

   a_level_b: assert property (
      wr_full && slot == 5'(S45) |=> second_output_drive_current == $past(pwdata[5:0]))
      else $error("second output level not updated");

   a_pd_bits: assert property (
      wr_full && slot == 5'(S44) |=>
         second_output_powerdown == $past(pwdata[7]) &&
         first_output_powerdown == $past(pwdata[6]))
      else $error("power-down bits not updated");

   a_mod_reset: assert property (
      wr_full && slot == 5'(S44) |=> modulator_reset_low == $past(pwdata[5]))
      else $error("modulator reset bit not updated");

   a_mod_order: assert property (
      wr_full && slot == 5'(S44) |=> modulator_order_select == $past(pwdata[2:0]))
      else $error("modulator order not updated");

   a_src_a: assert property (
      wr_full && slot == 5'(S45) |=> first_output_source_select == $past(pwdata[12:11]))
      else $error("first output source not updated");

   a_src_b: assert property (
      wr_full && slot == 5'(S46) |=> second_output_source_select == $past(pwdata[1:0]))
      else $error("second output source not updated");

   a_no_write_hold: assert property (
      !(fire && pwrite) |=> state.regs == $past(state.regs))
      else $error("register changed without a write");

   a_unmapped_keeps: assert property (
      fire && pwrite && !hit |=> state.regs == $past(state.regs))
      else $error("refused write changed a register");

   a_ctrl_hold: assert property (
      !(fire && pwrite) |=> $stable(first_output_drive_current) &&
         $stable(second_output_drive_current) && $stable(modulator_order_select))
      else $error("control output moved without a write");

   // Partial writes: the lane left low keeps its byte
   a_upper_lane: assert property (
      fire && pwrite && hit && pstrb[1:0] == 2'h2 |=>
         state.regs[$past(slot)] == {$past(pwdata[15:8]), $past(state.regs[slot][7:0])})
      else $error("upper-lane write disturbed the low byte");

   a_low_lane: assert property (
      fire && pwrite && hit && pstrb[1:0] == 2'h1 |=>
         state.regs[$past(slot)] == {$past(state.regs[slot][15:8]), $past(pwdata[7:0])})
      else $error("low-lane write disturbed the high byte");

   a_no_lane: assert property (
      fire && pwrite && pstrb[1:0] == 2'h0 |=> state.regs == $past(state.regs))
      else $error("write with both low lanes off changed a register");

   // Bus answer: only in the access cycle, upper half always zero
   a_ready_after_setup: assert property (pready |-> $past(setup))
      else $error("pready without a preceding setup");

   a_idle_quiet: assert property (
      !pready |-> !pslverr && prdata == 32'h0000_0000)
      else $error("bus answer left standing outside the access cycle");

   a_upper_zero: assert property (prdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   a_err_no_data: assert property (pslverr |-> prdata == 32'h0000_0000)
      else $error("refused access returned data");

   a_err_one_cycle: assert property (pslverr |=> !pslverr)
      else $error("error answer stood longer than one cycle");

   a_write_no_err: assert property (fire && hit |-> !pslverr)
      else $error("mapped access answered with an error");

   // Reset brings every word and every control to its reset value
   a_reset_words: assert property (
      $rose(presetn) |-> state.regs == REG_RESET && !pready && !pslverr)
      else $error("bank not at reset values after reset");

   a_reset_outputs: assert property (
      $rose(presetn) |->
         first_output_drive_current == 6'h22 && second_output_drive_current == 6'h22 &&
         second_output_powerdown && !first_output_powerdown &&
         modulator_reset_low && modulator_order_select == 3'h2 &&
         first_output_source_select == 2'h0 && second_output_source_select == 2'h0)
      else $error("control outputs not at reset values");

   // Main scenarios
   // Full and partial writes, a read of the last control word, a refused
   // access and a transfer that follows another without an idle cycle
   c_write_ctrl:  cover property (wr_full && slot == 5'(S44));
   c_read_src_b:  cover property (fire && !pwrite && hit && slot == 5'(S46));
   c_unmapped:    cover property (fire && state.err);
   c_back2back:   cover property (fire ##1 setup ##1 fire);
   c_lane_write:  cover property (fire && pwrite && hit && pstrb[1:0] != 2'h3);

endmodule : socr_regs

// ---- hw/socr_pkg.sv ----
// Package for the synthesizer output configuration register bank.
// Assumes a 32-bit APB slave, one 16-bit register per aligned word.
package socr_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL = 8'h2c;
   localparam logic [7:0] IDX_OUTPUT_B_LEVEL_AND_A_SOURCE       = 8'h2d;
   localparam logic [7:0] IDX_OUTPUT_B_SOURCE_SELECT            = 8'h2e;
   localparam logic [7:0] IDX_FIXED_SETTING_2F                  = 8'h2f;
   localparam logic [7:0] IDX_FIXED_SETTING_30                  = 8'h30;
   localparam logic [7:0] IDX_FIXED_SETTING_31                  = 8'h31;
   localparam logic [7:0] IDX_FIXED_SETTING_32                  = 8'h32;
   localparam logic [7:0] IDX_FIXED_SETTING_33                  = 8'h33;
   localparam logic [7:0] IDX_FIXED_SETTING_34                  = 8'h34;
   localparam logic [7:0] IDX_FIXED_SETTING_35                  = 8'h35;
   localparam logic [7:0] IDX_FIXED_SETTING_36                  = 8'h36;
   localparam logic [7:0] IDX_FIXED_SETTING_37                  = 8'h37;
   localparam logic [7:0] IDX_FIXED_SETTING_38                  = 8'h38;
   localparam int         NUM_REGS = 13;                      // Registers in the bank
   localparam logic [7:0] IDX_FIRST = IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL;
   localparam logic [7:0] IDX_LAST  = IDX_FIXED_SETTING_38;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int DRIVE_A_LSB   = 8;                          // First output level 13:8
   localparam int DRIVE_W       = 6;                          // Level field width
   localparam int PD_B_BIT      = 7;                          // Second output power-down
   localparam int PD_A_BIT      = 6;                          // First output power-down
   localparam int MOD_RST_BIT   = 5;                          // Modulator reset, low active
   localparam int MOD_ORDER_LSB = 0;                          // Modulator order 2:0
   localparam int MOD_ORDER_W   = 3;
   localparam int SRC_A_LSB     = 11;                         // First output source 12:11
   localparam int SRC_W         = 2;
   localparam int DRIVE_B_LSB   = 0;                          // Second output level 5:0
   localparam int SRC_B_LSB     = 0;                          // Second output source 1:0

   // ----------------------------------------------------------------
   // Modulator order and source codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SOCR_ORDER_INTEGER = 3'h0,
      SOCR_ORDER_FIRST   = 3'h1,
      SOCR_ORDER_SECOND  = 3'h2,
      SOCR_ORDER_THIRD   = 3'h3
   } socr_order_t;
   localparam logic [1:0] SRC_CHANNEL_DIV = 2'h0;             // Channel divider
   localparam logic [1:0] SRC_OSCILLATOR  = 2'h1;             // Oscillator direct
   localparam logic [1:0] SRC_SYS_REF     = 2'h2;             // System reference (B only)

   // ----------------------------------------------------------------
   // Reset values, listed from index 0x38 down to 0x2c
   // ----------------------------------------------------------------
   localparam logic [NUM_REGS-1:0][15:0] REG_RESET = {
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0420, 16'h0080, 16'h0080,
      16'h4180, 16'h03e0, 16'h0300, 16'h07f0, 16'hc622, 16'h22a2
   };

endpackage : socr_pkg

// ---- tb/socr_regs_tb.sv ----
// Self-checking bench for the output and modulator configuration registers.
// Assumes socr_regs answers APB with zero wait states and 16-bit registers.
`timescale 1ns/1ns

module testbench;
   import socr_pkg::*;

   // ----------------------------------------------------------------
   // Bench signals
   // ----------------------------------------------------------------
   logic        pclk;                                   // 100 MHz clock
   logic        presetn;                                // Reset, low active
   logic        psel;                                   // APB select
   logic        penable;                                // APB access phase
   logic        pwrite;                                 // APB direction
   logic [11:0] paddr;                                  // APB byte address
   logic [31:0] pwdata;                                 // APB write data
   logic [3:0]  pstrb;                                  // APB byte lanes
   logic        pready;                                 // APB answer
   logic [31:0] prdata;                                 // APB read data
   logic        pslverr;                                // APB error
   logic [21:0] outs;                                   // All control outputs
   int          n_errors;                               // Mismatches
   int          cmp_count;                              // Comparisons
   int          cyc;                                    // Timeout counter
   logic [31:0] rd;                                     // Last read data
   logic        err;                                    // Last error flag
   logic [5:0]  drv;                                    // Drive level under test
   logic [1:0]  kk;                                     // Loop code
   // Reset values, index order from 0x2c
   logic [15:0] rst_tbl [13] = '{16'h22a2, 16'hc622, 16'h07f0, 16'h0300, 16'h03e0,
      16'h4180, 16'h0080, 16'h0080, 16'h0420, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   // Programming values that software must load, index order from 0x2c
   logic [15:0] prg_tbl [13] = '{16'h22a2, 16'hc0e2, 16'h07fc, 16'h0300, 16'h0300,
      16'h4180, 16'h0000, 16'h0080, 16'h0420, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   // ----------------------------------------------------------------
   // Device under test
   // ----------------------------------------------------------------
   socr_regs socr_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr),
      .first_output_drive_current(outs[21:16]), .second_output_drive_current(outs[15:10]),
      .first_output_powerdown(outs[9]), .second_output_powerdown(outs[8]),
      .modulator_reset_low(outs[7]), .modulator_order_select(outs[6:4]),
      .first_output_source_select(outs[3:2]), .second_output_source_select(outs[1:0]));

   // Clock generation
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Cut a hang short
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; request held until pready is sampled high
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] wd,
                       input logic [3:0] st);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {16'h0000, wd};
      pstrb   <= st;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait as long as the slave asks; only the bench timeout ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   // Register write by index, byte lanes given by the caller
   task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] st);
      xfer(1'b1, {2'b00, idx, 2'b00}, d, st);
      chk({31'h0, err}, 32'h0);
   endtask : wr_reg

   // Register read by index with expected value
   task automatic rd_reg(input logic [7:0] idx, input logic [15:0] exp);
      xfer(1'b0, {2'b00, idx, 2'b00}, 16'h0000, 4'hf);
      chk(rd, {16'h0000, exp});
      chk({31'h0, err}, 32'h0);
   endtask : rd_reg

   // Hold reset for five cycles
   task automatic reset_dut();
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
   endtask : reset_dut

   // Outputs and every register at reset value
   task automatic check_reset();
      chk({10'h0, outs}, {10'h0, 6'h22, 6'h22, 1'b0, 1'b1, 1'b1, 3'h2, 2'h0, 2'h0});
      for (int i = 0; i < 13; i++) rd_reg(8'(8'h2c + i), rst_tbl[i]);
   endtask : check_reset

   // Print counts and verdict, end the run
   task automatic results();
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      n_errors = 0;
      cmp_count = 0;
      cyc = 0;
      reset_dut();
      check_reset();
      // Field decode: every order code, levels from 0 to 0x1f, all source codes
      for (int k = 0; k < 4; k++) begin
         kk = 2'(k);
         drv = 6'h1f >> (2 * k);
         wr_reg(IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL, {2'b00, drv, kk[1], kk[0],
                kk[0] ^ kk[1], 2'b00, 1'b0, kk}, 4'hf);
         wr_reg(IDX_OUTPUT_B_LEVEL_AND_A_SOURCE, {3'h6, 1'b0, kk[0], 5'h03, 6'h1f - drv},
                4'hf);
         wr_reg(IDX_OUTPUT_B_SOURCE_SELECT, {14'h01ff, 2'(k % 3)}, 4'hf);
         rd_reg(IDX_OUTPUT_B_SOURCE_SELECT, {14'h01ff, 2'(k % 3)});
         chk({10'h0, outs}, {10'h0, drv, 6'h1f - drv, kk[0], kk[1], kk[0] ^ kk[1],
             1'b0, kk, 1'b0, kk[0], 2'(k % 3)});
      end
      // Reserved registers store arbitrary patterns
      for (int i = 3; i < 13; i++) wr_reg(8'(8'h2c + i), 16'(16'ha5c3 ^ (16'h1111 * i)), 4'hf);
      for (int i = 3; i < 13; i++) rd_reg(8'(8'h2c + i), 16'(16'ha5c3 ^ (16'h1111 * i)));
      // Required programming values load and read back
      for (int i = 0; i < 13; i++) wr_reg(8'(8'h2c + i), prg_tbl[i], 4'hf);
      for (int i = 0; i < 13; i++) rd_reg(8'(8'h2c + i), prg_tbl[i]);
      chk({10'h0, outs}, {10'h0, 6'h22, 6'h22, 1'b0, 1'b1, 1'b1, 3'h2, 2'h0, 2'h0});
      // Upper lane only
      wr_reg(IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL, 16'hffff, 4'b0010);
      rd_reg(IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL, 16'hffa2);
      // Unmapped and misaligned accesses refused, nothing stored
      xfer(1'b0, 12'he4, 16'h0000, 4'hf);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      xfer(1'b1, 12'h0ac, 16'h1234, 4'hf);
      chk({31'h0, err}, 32'h1);
      xfer(1'b1, 12'hb2, 16'h0000, 4'hf);
      chk({31'h0, err}, 32'h1);
      rd_reg(IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL, 16'hffa2);
      // Low lane only, then only the lanes that have no storage
      wr_reg(IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL, 16'h0000, 4'b0001);
      rd_reg(IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL, 16'hff00);
      wr_reg(IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL, 16'h1234, 4'b1100);
      rd_reg(IDX_OUTPUT_A_LEVEL_AND_MODULATOR_CTRL, 16'hff00);
      // Second reset in mid-run
      reset_dut();
      check_reset();
      results();
   end

endmodule : testbench
